// [hw/msp_pkg.sv]
// Constants and types for the multimode serial port block
package msp_pkg;
    localparam int NPORT = 5;
    localparam int FIFO_DEPTH = 8;
    // Baud base: 16x clock for divisor 1 = 115200, made by a phase accumulator
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned BASE_HZ = 1_843_200;
    localparam longint unsigned EXT_MULT = 4;
    localparam int ACC_W = 24;
    localparam logic [ACC_W-1:0] ACC_INC = ACC_W'((BASE_HZ << ACC_W) / CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_INC_FAST = ACC_W'(((BASE_HZ * EXT_MULT) << ACC_W) / CLK_HZ);
    // UART register offsets
    localparam logic [2:0] UR_DATA = 3'h0;
    localparam logic [2:0] UR_IER  = 3'h1;
    localparam logic [2:0] UR_IIR  = 3'h2;
    localparam logic [2:0] UR_LCR  = 3'h3;
    localparam logic [2:0] UR_MCR  = 3'h4;
    localparam logic [2:0] UR_LSR  = 3'h5;
    localparam logic [2:0] UR_MSR  = 3'h6;
    localparam logic [2:0] UR_SCR  = 3'h7;
    // Field positions
    localparam int LCR_STB = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EPS = 4;
    localparam int LCR_BRK = 6;
    localparam int LCR_DLAB = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT2 = 3;
    localparam int DLM_EXT = 7;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int IER_RX = 0;
    localparam int IER_THRE = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam int SY_RXD = 0;
    localparam int SY_CTSP = 1;
    localparam int SY_DCD = 2;
    localparam int SY_DSR = 3;
    localparam int SY_RI = 4;
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LS   = 4'h6;
    localparam logic [3:0] IIR_RX   = 4'h4;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_MS   = 4'h0;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    // Setup space
    localparam logic [15:0] CFG_BASE  = 16'h0CC0;
    localparam logic [1:0] CFG_CTRL   = 2'h0;
    localparam logic [1:0] CFG_BASELO = 2'h1;
    localparam logic [1:0] CFG_BASEHI = 2'h2;
    localparam logic [2:0] CFG_TRCTL  = 3'h5;
    localparam int CTRL_EN = 0;
    localparam int CTRL_AUTO = 3;
    localparam logic [NPORT-1:0][15:0] RST_BASE =
        {16'h02E0, 16'h02E8, 16'h03E8, 16'h02F8, 16'h03F8};
    localparam logic [NPORT-1:0][3:0] RST_IRQ = {4'h5, 4'hB, 4'hA, 4'h3, 4'h4};

    typedef enum logic [1:0] {
        MSP_RS232 = 2'b00,
        MSP_RS422 = 2'b01,
        MSP_RS485 = 2'b10
    } msp_mode_t;

    typedef struct packed {
        logic        en;
        msp_mode_t   mode;
        logic        auto_dir;
        logic [3:0]  irq_sel;
        logic [15:0] base;
        logic [7:0]  dll;
        logic [7:0]  dlm;
        logic [7:0]  lcr;
        logic [7:0]  scr;
        logic [7:0]  rbr;
        logic [3:0]  ier;
        logic [4:0]  mcr;
        logic        dr;
        logic        oe;
        logic        pe;
        logic        fe;
        logic        thre_pend;
        logic        thre_q;
        logic [3:0]  msr_d;
        logic [3:0]  msr_q;
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [15:0] div_cnt;
        logic        tx_busy;
        logic [11:0] tx_sh;
        logic [3:0]  tx_bits;
        logic [3:0]  tx_sub;
        logic        rx_act;
        logic [9:0]  rx_sh;
        logic [3:0]  rx_idx;
        logic [3:0]  rx_sub;
        logic        out_tx;
        logic        out_rts;
        logic        drv;
    } msp_port_t;

    typedef struct packed {
        msp_port_t [NPORT-1:0] port;
        logic [NPORT-1:0]      trctl;
        logic [ACC_W-1:0]      acc_b;
        logic [ACC_W-1:0]      acc_f;
        logic [7:0]            rdata;
        logic [15:0]           irq;
        logic                  dtr;
    } msp_state_t;
endpackage : msp_pkg

// [hw/msp_top.sv]
// Five-port multimode serial controller with its transmit FIFO
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module msp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } msp_fifo_st_t;
    msp_fifo_st_t st_ff, nxt_st;
    logic push, pop;

    assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign out_data  = st_ff.mem[st_ff.rp];

    // Pointer walk; flush wins over any push or pop in the same cycle
    always_comb begin
        nxt_st = st_ff;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (flush) begin
            nxt_st.rp  = st_ff.wp;
            nxt_st.cnt = '0;
        end else begin
            if (push) begin
                nxt_st.mem[st_ff.wp] = in_data;
                nxt_st.wp = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
            end
            if (pop) begin
                nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
            end
            nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule : msp_fifo

module msp_top
    import msp_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire logic [15:0]       bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [7:0]        bus_rdata,
    input  wire logic [NPORT-1:0]  line_rxd,
    input  wire logic [NPORT-1:0]  line_ctsp,
    output logic      [NPORT-1:0]  line_txd,
    output logic      [NPORT-1:0]  line_rtsp,
    output logic      [NPORT-1:0]  line_drv_en,
    input  wire logic              com1_dcd,
    input  wire logic              com1_dsr,
    input  wire logic              com1_ri,
    output logic                   com1_dtr,
    output logic      [15:0]       irq_line
);
    import msp_pkg::*;

    msp_state_t st_ff, nxt_st;
    logic [NPORT-1:0]       push, pop, flush, fifo_rdy, fifo_ov;
    logic [NPORT-1:0][7:0]  fifo_dat;

    // Build one character frame: start, data, optional parity, stop bits
    function automatic logic [15:0] msp_frame(input logic [7:0] d, input logic [7:0] lcr);
        logic [11:0] f;
        logic [3:0]  wl;
        logic [3:0]  n;
        logic        par;
        f   = 12'hFFF;
        wl  = 4'h5 + {2'h0, lcr[1:0]};
        par = (^(d & (8'hFF >> (4'h8 - wl)))) ^ ~lcr[LCR_EPS];
        f[0] = 1'b0;
        for (int j = 0; j < 8; j++) begin
            if (j < int'(wl)) f[j+1] = d[j];
        end
        if (lcr[LCR_PEN]) f[wl+4'h1] = par;
        n = 4'h1 + wl + {3'h0, lcr[LCR_PEN]} + (lcr[LCR_STB] ? 4'h2 : 4'h1);
        return {n, f};
    endfunction : msp_frame

    // One transmit FIFO per port, pins driven from registered state
    for (genvar g = 0; g < NPORT; g++) begin : g_port
        msp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
            .clk_sys   (clk_sys),
            .reset     (reset),
            .ce        (ce),
            .flush     (flush[g]),
            .in_valid  (push[g]),
            .in_ready  (fifo_rdy[g]),
            .in_data   (bus_wdata),
            .out_valid (fifo_ov[g]),
            .out_ready (pop[g]),
            .out_data  (fifo_dat[g])
        );
        assign line_txd[g]    = st_ff.port[g].out_tx;
        assign line_rtsp[g]   = st_ff.port[g].out_rts;
        assign line_drv_en[g] = st_ff.port[g].drv;
    end

    assign bus_rdata = st_ff.rdata;
    assign irq_line  = st_ff.irq;
    assign com1_dtr  = st_ff.dtr;

    msp_port_t  c, p;
    logic       cb, cf, cfg_hit, hit, ext, tk, os, rxin, cts, diff, txb, thre;
    logic [15:0] dv, fr;
    logic [3:0]  id, wl, k, msr_now;
    logic [7:0]  rv, dm;
    logic [9:0]  tmp;

    always_comb begin
        nxt_st = st_ff;
        push = '0;
        pop = '0;
        flush = '0;
        c = '0;
        p = '0;
        hit = 1'b0;
        ext = 1'b0;
        tk = 1'b0;
        os = 1'b0;
        rxin = 1'b1;
        cts = 1'b0;
        diff = 1'b0;
        txb = 1'b1;
        thre = 1'b0;
        dv = '0;
        fr = '0;
        id = IIR_NONE;
        wl = '0;
        k = '0;
        msr_now = '0;
        rv = '0;
        dm = '0;
        tmp = '0;
        nxt_st.rdata = 8'h00;
        nxt_st.irq = 16'h0000;
        // Shared baud bases; carries give normal and 4x 16x-ticks
        {cb, nxt_st.acc_b} = {1'b0, st_ff.acc_b} + {1'b0, ACC_INC};
        {cf, nxt_st.acc_f} = {1'b0, st_ff.acc_f} + {1'b0, ACC_INC_FAST};
        cfg_hit = bus_addr[15:5] == CFG_BASE[15:5];
        if (cfg_hit && bus_addr[4:2] == CFG_TRCTL && bus_addr[1:0] == 2'h0) begin
            if (bus_wr) nxt_st.trctl = bus_wdata[NPORT-1:0];
            if (bus_rd) nxt_st.rdata = {3'h0, st_ff.trctl};
        end
        for (int i = 0; i < NPORT; i++) begin
            c = st_ff.port[i];
            p = c;
            // differential modes exist on ports two to five only
            diff = (i != 0) && (c.mode != MSP_RS232);
            // Two-stage pin synchronisers
            p.s1 = {(i == 0) ? com1_ri : 1'b0, (i == 0) ? com1_dsr : 1'b0,
                    (i == 0) ? com1_dcd : 1'b0, line_ctsp[i], line_rxd[i]};
            p.s2 = c.s1;
            // RxD+ on the CTS position, RxD- on the RXD position
            rxin = diff ? c.s2[SY_CTSP] : c.s2[SY_RXD];
            cts  = diff ? 1'b1 : c.s2[SY_CTSP];
            // full modem lines only reach port one
            msr_now = {c.s2[SY_DCD], c.s2[SY_RI], c.s2[SY_DSR], cts};
            thre = !fifo_ov[i];
            // Interrupt identity, highest priority first
            if (c.ier[IER_LS] && (c.oe || c.pe || c.fe)) id = IIR_LS;
            else if (c.ier[IER_RX] && c.dr) id = IIR_RX;
            else if (c.ier[IER_THRE] && c.thre_pend) id = IIR_THRE;
            else if (c.ier[IER_MS] && (c.msr_d != 4'h0)) id = IIR_MS;
            else id = IIR_NONE;
            // firmware setup of enable, mode, interrupt and base
            if (cfg_hit && bus_addr[4:2] == 3'(i)) begin
                if (bus_wr && bus_addr[1:0] == CFG_CTRL) begin
                    p.en = bus_wdata[CTRL_EN];
                    // port one stays RS-232 whatever is written
                    p.mode = (i == 0) ? MSP_RS232 : msp_mode_t'(bus_wdata[2:1]);
                    p.auto_dir = bus_wdata[CTRL_AUTO];
                    p.irq_sel = bus_wdata[7:4];
                end
                if (bus_wr && bus_addr[1:0] == CFG_BASELO) p.base[7:0] = bus_wdata;
                if (bus_wr && bus_addr[1:0] == CFG_BASEHI) p.base[15:8] = bus_wdata;
                if (bus_rd) begin
                    case (bus_addr[1:0])
                        CFG_CTRL:   nxt_st.rdata = {c.irq_sel, c.auto_dir, c.mode, c.en};
                        CFG_BASELO: nxt_st.rdata = c.base[7:0];
                        CFG_BASEHI: nxt_st.rdata = c.base[15:8];
                        default:    nxt_st.rdata = 8'h00;
                    endcase
                end
            end
            // a disabled port ignores its address window
            hit = c.en && !cfg_hit && (bus_addr[15:3] == c.base[15:3]);
            if (hit && bus_wr) begin
                case (bus_addr[2:0])
                    UR_DATA: begin
                        if (c.lcr[LCR_DLAB]) p.dll = bus_wdata;
                        else begin
                            // A full FIFO drops the byte, so only push when it has room
                            push[i] = fifo_rdy[i];
                            p.thre_pend = 1'b0;
                        end
                    end
                    UR_IER: begin
                        if (c.lcr[LCR_DLAB]) p.dlm = bus_wdata;
                        else p.ier = bus_wdata[3:0];
                    end
                    UR_IIR: begin
                        if (bus_wdata[FCR_RXCLR]) p.dr = 1'b0;
                        flush[i] = bus_wdata[FCR_TXCLR];
                    end
                    UR_LCR:  p.lcr = bus_wdata;
                    UR_MCR:  p.mcr = bus_wdata[4:0];
                    UR_SCR:  p.scr = bus_wdata;
                    default: p.scr = c.scr;
                endcase
            end
            // UART reads and their clearing side effects
            if (hit && bus_rd) begin
                case (bus_addr[2:0])
                    UR_DATA: begin
                        rv = c.lcr[LCR_DLAB] ? c.dll : c.rbr;
                        if (!c.lcr[LCR_DLAB]) p.dr = 1'b0;
                    end
                    UR_IER: rv = c.lcr[LCR_DLAB] ? c.dlm : {4'h0, c.ier};
                    UR_IIR: begin
                        rv = {4'hC, id};
                        if (id == IIR_THRE) p.thre_pend = 1'b0;
                    end
                    UR_LCR: rv = c.lcr;
                    UR_MCR: rv = {3'h0, c.mcr};
                    UR_LSR: begin
                        rv = {1'b0, thre && !c.tx_busy, thre, 1'b0, c.fe, c.pe, c.oe, c.dr};
                        p.oe = 1'b0;
                        p.pe = 1'b0;
                        p.fe = 1'b0;
                    end
                    UR_MSR: begin
                        rv = {msr_now, c.msr_d};
                        p.msr_d = 4'h0;
                    end
                    default: rv = c.scr;
                endcase
                nxt_st.rdata = rv;
            end
            // Modem deltas; a change in the reading cycle still sets
            p.msr_q = msr_now;
            if (msr_now[0] != c.msr_q[0]) p.msr_d[0] = 1'b1;
            if (msr_now[1] != c.msr_q[1]) p.msr_d[1] = 1'b1;
            if (c.msr_q[2] && !msr_now[2]) p.msr_d[2] = 1'b1;
            if (msr_now[3] != c.msr_q[3]) p.msr_d[3] = 1'b1;
            // Empty transmit FIFO raises the pending THRE source
            p.thre_q = thre;
            if (thre && !c.thre_q) p.thre_pend = 1'b1;
            // divisor top bit selects the 4x base on ports two to five
            ext = (i != 0) && c.dlm[DLM_EXT];
            dv = ext ? {1'b0, c.dlm[6:0], c.dll} : {c.dlm, c.dll};
            tk = ext ? cf : cb;
            os = 1'b0;
            if (tk) begin
                if (c.div_cnt + 16'h0001 >= dv) begin
                    p.div_cnt = 16'h0000;
                    os = 1'b1;
                end else begin
                    p.div_cnt = c.div_cnt + 16'h0001;
                end
            end
            // Transmitter: 16 oversample ticks per bit
            if (c.tx_busy) begin
                if (os) begin
                    p.tx_sub = c.tx_sub + 4'h1;
                    if (c.tx_sub == OVS_LAST) begin
                        p.tx_sh = {1'b1, c.tx_sh[11:1]};
                        p.tx_bits = c.tx_bits - 4'h1;
                        if (c.tx_bits == 4'h1) p.tx_busy = 1'b0;
                    end
                end
            end else if (fifo_ov[i] && c.en) begin
                pop[i] = 1'b1;
                fr = msp_frame(fifo_dat[i], c.lcr);
                p.tx_bits = fr[15:12];
                p.tx_sh = fr[11:0];
                p.tx_sub = 4'h0;
                p.tx_busy = 1'b1;
            end
            // Receiver: mid-bit sampling, flags set after any clearing read
            wl = 4'h5 + {2'h0, c.lcr[1:0]};
            k = wl + {3'h0, c.lcr[LCR_PEN]} + 4'h1;
            if (os && c.en) begin
                if (!c.rx_act) begin
                    if (!rxin) begin
                        p.rx_act = 1'b1;
                        p.rx_sub = 4'h0;
                        p.rx_idx = 4'h0;
                    end
                end else begin
                    p.rx_sub = c.rx_sub + 4'h1;
                    if (c.rx_sub == OVS_MID) begin
                        if (c.rx_idx == 4'h0) begin
                            if (rxin) p.rx_act = 1'b0;
                            else p.rx_idx = 4'h1;
                        end else begin
                            p.rx_sh = {rxin, c.rx_sh[9:1]};
                            p.rx_idx = c.rx_idx + 4'h1;
                            if (c.rx_idx == k) begin
                                tmp = p.rx_sh >> (4'hA - k);
                                dm = tmp[7:0] & (8'hFF >> (4'h8 - wl));
                                p.rbr = dm;
                                if (c.dr && p.dr) p.oe = 1'b1;
                                p.dr = 1'b1;
                                if (!rxin) p.fe = 1'b1;
                                if (c.lcr[LCR_PEN] && (tmp[wl] != ((^dm) ^ ~c.lcr[LCR_EPS])))
                                    p.pe = 1'b1;
                                p.rx_act = 1'b0;
                            end
                        end
                    end
                end
            end
            // Line pins: idle mark, break forces space
            txb = (c.tx_busy ? c.tx_sh[0] : 1'b1) && !c.lcr[LCR_BRK];
            if (!c.en) begin
                p.out_tx = 1'b1;
                p.out_rts = 1'b0;
                p.drv = 1'b0;
            end else if (diff) begin
                // TxD+ on the RTS position, TxD- on the TXD position
                p.out_rts = txb;
                p.out_tx = !txb;
                if (c.auto_dir && i >= 1 && i <= 3) begin
                    p.drv = c.tx_busy || fifo_ov[i];
                end else begin
                    p.drv = st_ff.trctl[i];
                end
            end else begin
                p.out_tx = txb;
                p.out_rts = c.mcr[MCR_RTS];
                p.drv = 1'b1;
            end
            if (c.en && c.mcr[MCR_OUT2] && id != IIR_NONE) nxt_st.irq[c.irq_sel] = 1'b1;
            nxt_st.port[i] = p;
        end
        nxt_st.dtr = st_ff.port[0].en && st_ff.port[0].mcr[MCR_DTR];
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff <= '0;
            for (int i = 0; i < NPORT; i++) begin
                st_ff.port[i].en <= 1'b1;
                st_ff.port[i].base <= RST_BASE[i];
                st_ff.port[i].irq_sel <= RST_IRQ[i];
                st_ff.port[i].out_tx <= 1'b1;
                st_ff.port[i].lcr <= 8'h03;
                st_ff.port[i].thre_q <= 1'b1;
            end
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule : msp_top

`default_nettype wire

// [testbench/msp_line_model.sv]
// Remote equipment that echoes each port's transmit legs back
`timescale 1ns/10ps
`default_nettype none
module msp_line_model
    import msp_pkg::*;
(
    input  wire logic [NPORT-1:0] line_txd,
    input  wire logic [NPORT-1:0] line_rtsp,
    input  wire logic [NPORT-1:0] line_drv_en,
    input  wire logic [NPORT-1:0] diff,
    output logic      [NPORT-1:0] line_rxd,
    output logic      [NPORT-1:0] line_ctsp
);
    // TxD+ lands on RxD+, TxD- on RxD
    // A released pair falls to failsafe mark, not the last bit
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            line_rxd[i] = line_txd[i];
            line_ctsp[i] = line_rtsp[i];
            if (diff[i] && !line_drv_en[i]) begin
                line_rxd[i] = 1'b0;
                line_ctsp[i] = 1'b1;
            end
        end
    end
endmodule : msp_line_model
`default_nettype wire

// [testbench/msp_top_assertions.sv]
// Port checker for the serial controller
`timescale 1ns/10ps
`default_nettype none
module msp_chk
    import msp_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic             ce,
    input wire logic             bus_wr,
    input wire logic             bus_rd,
    input wire logic [7:0]       bus_rdata,
    input wire logic [NPORT-1:0] line_txd,
    input wire logic [NPORT-1:0] line_rtsp,
    input wire logic [NPORT-1:0] line_drv_en,
    input wire logic             com1_dtr
);
    logic [2:0] rst_age_ff;
    logic [2:0] wr_age_ff;
    // Saturating ages, so a long idle never wraps
    always_ff @(posedge clk_sys) begin
        rst_age_ff <= reset ? 3'h0 : rst_age_ff + 3'(rst_age_ff != 3'h7);
        wr_age_ff <= (reset | bus_wr) ? 3'h0 : wr_age_ff + 3'(wr_age_ff != 3'h7);
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    rdata_hold_a: assert property ($past(ce) && !$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data out of cycle");
    reset_quiet_a: assert property (rst_age_ff == 3'h0 |-> !line_drv_en && !com1_dtr)
        else $error("outputs active at reset");
    dtr_stable_a: assert property (
        rst_age_ff == 3'h7 && wr_age_ff > 3'h3 |-> $stable(com1_dtr))
        else $error("DTR moved alone");
    com1_drv_a: assert property (rst_age_ff == 3'h7 |-> line_drv_en[0])
        else $error("first port driver off");
    manual_drv_a: assert property (
        rst_age_ff == 3'h7 && wr_age_ff > 3'h3 |-> $stable(line_drv_en[4]))
        else $error("manual driver moved alone");
    auto_on_a: assert property (
        rst_age_ff == 3'h7 && $rose(line_drv_en[1]) |-> wr_age_ff < 3'h5)
        else $error("auto driver rose alone");
    auto_off_a: assert property (
        wr_age_ff == 3'h7 && $fell(line_drv_en[1]) |-> line_rtsp[1] && !line_txd[1])
        else $error("auto driver dropped early");
    ce_freeze_a: assert property (!ce |=> $stable(line_txd) && $stable(line_drv_en))
        else $error("line moved while frozen");
endmodule : msp_chk

bind msp_top msp_chk u_chk (
    .clk_sys, .reset, .ce, .bus_wr, .bus_rd, .bus_rdata, .line_txd, .line_rtsp,
    .line_drv_en, .com1_dtr
);
`default_nettype wire

// [testbench/msp_top_tb.sv]
// Bench: registers, manual and automatic drivers, FIFO burst
`timescale 1ns/10ps
`default_nettype none
module msp_top_tb;
    import msp_pkg::*;
    logic             clk_sys, reset, ce, bus_wr, bus_rd, com1_dcd, com1_dsr, com1_ri, com1_dtr;
    logic [15:0]      bus_addr, irq_line;
    logic [7:0]       bus_wdata, bus_rdata, d;
    logic [NPORT-1:0] line_rxd, line_ctsp, line_txd, line_rtsp, line_drv_en, diff;
    logic [7:0]       q [10];
    int               n_fail = 0, n_tests = 0, cyc = 0, n_rx = 0;
    msp_top DUT (
        .clk_sys, .reset, .ce, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .line_rxd, .line_ctsp, .line_txd, .line_rtsp, .line_drv_en, .com1_dcd,
        .com1_dsr, .com1_ri, .com1_dtr, .irq_line
    );
    msp_line_model u_line (.line_txd, .line_rtsp, .line_drv_en, .diff, .line_rxd, .line_ctsp);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Hang guard above the burst drain time
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd
    // Setup control byte of one port
    function automatic logic [7:0] cfg(input int i, input logic au, input msp_mode_t m,
                                       input logic en);
        return {RST_IRQ[i], au, m, en};
    endfunction : cfg
    initial begin
        {reset, ce, bus_wr, bus_rd, com1_dcd, com1_dsr, com1_ri} = 7'h60;
        {bus_addr, bus_wdata, diff} = '0;
        void'($urandom(32'hD603038B));
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < NPORT; i++) begin
            q[i] = 8'($urandom);
            wr(RST_BASE[i] + 16'h7, q[i]);
            rd(RST_BASE[i] + 16'h7);
            chk(d, q[i]);
        end
        // disabled port and unmapped place read zero
        wr(CFG_BASE + 16'hC, cfg(3, 1'b0, MSP_RS232, 1'b0));
        rd(RST_BASE[3] + 16'h7);
        chk(d, 8'h00);
        rd(16'h0100);
        chk(d, 8'h00);
        wr(CFG_BASE + 16'hC, cfg(3, 1'b0, MSP_RS232, 1'b1));
        // DTR and OUT2 out, modem lines in, modem interrupt routed
        wr(RST_BASE[0] + 16'h4, 8'h09);
        wr(RST_BASE[0] + 16'h1, 8'h08);
        {com1_dcd, com1_dsr, com1_ri} <= 3'h7;
        repeat (6) @(posedge clk_sys);
        chk(8'(com1_dtr), 8'h01);
        chk(8'(irq_line == (16'h0001 << RST_IRQ[0])), 8'h01);
        rd(RST_BASE[0] + 16'h6);
        chk(d, 8'hEA);
        // Reading the deltas drops the routed line
        repeat (3) @(posedge clk_sys);
        chk(8'(irq_line == 16'h0000), 8'h01);
        ce <= 1'b0;
        repeat (5) @(posedge clk_sys);
        ce <= 1'b1;
        // port five stays manual despite auto bit
        diff <= 5'h12;
        wr(CFG_BASE + 16'h10, cfg(4, 1'b1, MSP_RS422, 1'b1));
        for (int k = 0; k < 3; k++) begin
            if (k > 0) wr(CFG_BASE + 16'h14, (k == 1) ? 8'h10 : 8'h00);
            repeat (4) @(posedge clk_sys);
            chk(8'(line_drv_en[4]), 8'(k == 1));
        end
        chk(8'(line_txd[4]), 8'h00);
        // Port two RS-485 auto, divisor 0x8001
        wr(CFG_BASE + 16'h4, cfg(1, 1'b1, MSP_RS485, 1'b1));
        wr(RST_BASE[1] + 16'h3, 8'h83);
        wr(RST_BASE[1], 8'h01);
        wr(RST_BASE[1] + 16'h1, 8'h80);
        wr(RST_BASE[1] + 16'h3, 8'h03);
        repeat (4) @(posedge clk_sys);
        chk(8'(line_drv_en[1]), 8'h00);
        // One past engine plus FIFO: the tenth is dropped
        for (int i = 0; i < 10; i++) begin
            q[i] = 8'($urandom);
            wr(RST_BASE[1], q[i]);
        end
        chk(8'(line_drv_en[1]), 8'h01);
        for (int p = 0; p < 2200; p++) begin
            repeat (20) @(posedge clk_sys);
            // Freeze mid-character; the checker sees the lines hold
            if (p == 50) begin
                ce <= 1'b0;
                repeat (5) @(posedge clk_sys);
                ce <= 1'b1;
            end
            rd(RST_BASE[1] + 16'h5);
            if (d[0] === 1'b1 && n_rx < 10) begin
                rd(RST_BASE[1]);
                chk(d, q[n_rx]);
                n_rx++;
            end
        end
        chk(8'(n_rx), 8'(FIFO_DEPTH + 1));
        chk(8'(line_drv_en[1]), 8'h00);
        end_of_test();
    end
endmodule : msp_top_tb
`default_nettype wire
